// ### verilog/qss_pkg.sv
// qss_pkg: constants and carrier types for the quad switch serial control block.
// assumes a single 100 MHz core clock; every use is written qss_pkg::name.
`default_nettype none
package qss_pkg;
	// core clock and time base
	localparam int CLK_PERIOD_NS     = 10;
	localparam int NS_PER_MS         = 1000000;
	localparam int TICK_CYCLES       = NS_PER_MS / CLK_PERIOD_NS;
	localparam int RETRY_INTERVAL_MS = 2000;

	// serial frame layout
	localparam int FRAME_BITS = 8;
	localparam int CNT_W      = 3;
	localparam int CH_COUNT   = 4;
	localparam int PAR_ODD    = 3;
	localparam int PAR_EVEN   = 2;
	localparam int PAR_ALL    = 1;
	localparam int PAR_ALL_N  = 0;

	// reset values
	localparam logic [3:0] CMD_RESET  = 4'h0;
	localparam logic [7:0] SHIFT_RESET = 8'h00;
	localparam logic [CNT_W-1:0] CNT_RESET = 3'h0;

	// received frame: commands for channels 4..1 then parity nibble
	typedef struct packed {
		logic [3:0] cmd;
		logic [3:0] parity;
	} qss_frame_t;

	// diagnostics frame: live flags then held flags, channels 4..1
	typedef struct packed {
		logic [3:0] live;
		logic [3:0] held;
	} qss_diag_t;

	// pins arriving from outside the core clock domain
	typedef struct packed {
		logic       spi_clk;
		logic       cs_n;
		logic       sdi;
		logic       reverse_detect;
		logic       global_off_n;
		logic [3:0] overtemp;
	} qss_pins_t;

	localparam int PINS_W = 9;
	// synchroniser reset: select high (idle), global off low, all else low
	localparam logic [8:0] PINS_RESET = 9'h080;

	// reverse current auto-retry states
	typedef enum logic {
		RT_IDLE,
		RT_HOLD
	} qss_retry_state_t;
endpackage
`default_nettype wire

// ### verilog/qss_serial_control.sv
// qss_serial_control: mode-0 serial command port, parity and count checking,
// thermal diagnostics and reverse current auto-retry for four low-side switches.
// assumes asynchronous pins from the host and analog monitors; one core clock.
`timescale 1ns/100ps
`default_nettype none

// Function
// RQ1: reverse current: fault low, all switches off
// RQ2: after interval restore commands, release fault high
// RQ3: new reverse current restarts a full interval; the sequencer ignores it until the hold ends
// RQ4: overtemperature channel off, auto restarts when cool
// RQ5: sample input on rise, shift output on fall
// RQ6: serial output undriven while select inactive
// RQ7: host keeps clock at or below 10 MHz; the bench host model runs it with an 80 ns period, 12.5 MHz
// RQ8: eight-bit frames, shifted bits pass onward
// RQ9: upper nibble commands, lower nibble parity
// RQ10: command one closes switch, zero opens it
// RQ11: four parity bits from command bits
// RQ12: parity mismatch keeps outputs, error output low
// RQ13: clock count not multiple of eight: error
// RQ14: error output changes only at select rise
// RQ15: select fall samples live and held flags
// RQ16: channel commanded off reports zero flags
// RQ17: held flag set by any active overload; the code sets it only on channels commanded on
// RQ18: held flag clears only if cool, no error
// RQ19: clock pulses ignored while select inactive
// RQ20: host holds clock low at select fall
// RQ21: count falling clock edges after select low
// RQ22: commands applied at select rise
// RQ23: shifted bits appear on output next byte
// RQ24: global off input forces all switches off
// RQ25: parity order odd, even, all, inverted all
// RQ26: count error does not update commands
// RQ27: error output returns high after clean frame
module qss_serial_control #(
	parameter int TICK_CYCLES = qss_pkg::TICK_CYCLES,      // core cycles per retry tick
	parameter int RETRY_TICKS = qss_pkg::RETRY_INTERVAL_MS // ticks in one retry interval
) (
	input  wire logic       core_clk,        // 100 MHz core clock
	input  wire logic       rst,             // synchronous reset, active high
	input  wire logic       spi_clk,         // serial clock pin
	input  wire logic       cs_n,            // chip select pin, active low
	input  wire logic       sdi,             // serial data in pin
	input  wire logic       reverse_detect,  // reverse current comparator
	input  wire logic       global_off_n,    // global disable pin, active low
	input  wire logic [3:0] overtemp,        // per-channel overtemperature flags
	output logic      [3:0] switch_on,       // switch gate drive, channels 4..1
	output logic            reverse_fault_n, // reverse fault output, active low
	output logic            frame_error_n,   // frame error output, active low
	output logic            sdo,             // serial data out
	output logic            sdo_oe           // serial data out enable
);
	localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
	localparam int RW = (RETRY_TICKS > 1) ? $clog2(RETRY_TICKS) : 1;
	localparam logic [TW-1:0] TICK_LAST  = TW'(TICK_CYCLES - 1);
	localparam logic [RW-1:0] RETRY_LAST = RW'(RETRY_TICKS - 1);

	logic [qss_pkg::PINS_W-1:0] sync1_reg;
	logic [qss_pkg::PINS_W-1:0] sync2_reg;
	logic [qss_pkg::PINS_W-1:0] sync3_reg;
	qss_pkg::qss_pins_t         pins_reg;
	qss_pkg::qss_pins_t         pins_prev_reg;
	logic [7:0]                 shift_reg;
	logic [qss_pkg::CNT_W-1:0]  fall_cnt_reg;
	logic                       any_fall_reg;
	logic [3:0]                 cmd_reg;
	logic [3:0]                 held_reg;
	logic [TW-1:0]              tick_cnt_reg;
	logic [RW-1:0]              retry_cnt_reg;
	qss_pkg::qss_retry_state_t  retry_state_reg;
	qss_pkg::qss_frame_t        rx_frame;
	qss_pkg::qss_diag_t         diag_now;
	logic [3:0]                 parity_calc;
	logic                       sel_fall;
	logic                       sel_rise;
	logic                       clk_rise;
	logic                       clk_fall;
	logic                       parity_ok;
	logic                       count_ok;
	logic                       frame_ok;
	logic [3:0]                 switch_next;
	logic [3:0]                 held_set;
	logic [3:0]                 held_clr;

	// three-stage pin synchroniser; a change counts once stages two and three agree
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			sync1_reg     <= qss_pkg::PINS_RESET;
			sync2_reg     <= qss_pkg::PINS_RESET;
			sync3_reg     <= qss_pkg::PINS_RESET;
			pins_reg      <= qss_pkg::qss_pins_t'(qss_pkg::PINS_RESET);
			pins_prev_reg <= qss_pkg::qss_pins_t'(qss_pkg::PINS_RESET);
		end
		else
		begin
			sync1_reg     <= {spi_clk, cs_n, sdi, reverse_detect, global_off_n, overtemp};
			sync2_reg     <= sync1_reg;
			sync3_reg     <= sync2_reg;
			pins_reg      <= qss_pkg::qss_pins_t'((sync2_reg & sync3_reg)
				| (pins_reg & (sync2_reg ^ sync3_reg)));
			pins_prev_reg <= pins_reg;
		end
	end

	// edge events; clock edges only count while selected
	assign sel_fall = pins_prev_reg.cs_n & ~pins_reg.cs_n;
	assign sel_rise = ~pins_prev_reg.cs_n & pins_reg.cs_n;
	assign clk_rise = ~pins_reg.cs_n & ~pins_prev_reg.spi_clk & pins_reg.spi_clk; // [RQ19]
	assign clk_fall = ~pins_reg.cs_n & pins_prev_reg.spi_clk & ~pins_reg.spi_clk; // [RQ19] [RQ21]

	// frame check: parity recomputed from received commands
	assign rx_frame = qss_pkg::qss_frame_t'(shift_reg); // [RQ9]
	assign parity_calc[qss_pkg::PAR_ODD]   = rx_frame.cmd[0] ^ rx_frame.cmd[2]; // [RQ11] [RQ25]
	assign parity_calc[qss_pkg::PAR_EVEN]  = rx_frame.cmd[1] ^ rx_frame.cmd[3]; // [RQ11] [RQ25]
	assign parity_calc[qss_pkg::PAR_ALL]   = ^rx_frame.cmd;                     // [RQ11] [RQ25]
	assign parity_calc[qss_pkg::PAR_ALL_N] = ~(^rx_frame.cmd);                  // [RQ11] [RQ25]
	assign parity_ok = (parity_calc == rx_frame.parity);                        // [RQ12]
	assign count_ok  = (fall_cnt_reg == qss_pkg::CNT_RESET);                    // [RQ13]
	assign frame_ok  = parity_ok & count_ok;

	// diagnostics seen by the host; channels commanded off read zero
	assign diag_now.live = pins_reg.overtemp & cmd_reg; // [RQ15] [RQ16]
	assign diag_now.held = held_reg & cmd_reg;          // [RQ15] [RQ16]

	// shift register: load diagnostics at select fall, sample data on rising edges
	always_ff @(posedge core_clk)
	begin
		if (rst)
			shift_reg <= qss_pkg::SHIFT_RESET;
		else if (sel_fall)
			shift_reg <= diag_now;                        // [RQ15]
		else if (clk_rise)
			shift_reg <= {shift_reg[6:0], pins_reg.sdi};  // [RQ5] [RQ8]
	end

	// serial output: changes on falling edges, driven only while selected
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			sdo    <= 1'b0;
			sdo_oe <= 1'b0;
		end
		else
		begin
			sdo_oe <= ~pins_reg.cs_n; // [RQ6]
			if (sel_fall)
				sdo <= diag_now.live[3];
			else if (clk_fall)
				sdo <= shift_reg[7];  // [RQ5] [RQ23]
		end
	end

	// falling-edge counter per transaction, modulo one frame
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			fall_cnt_reg <= qss_pkg::CNT_RESET;
			any_fall_reg <= 1'b0;
		end
		else if (sel_fall)
		begin
			fall_cnt_reg <= qss_pkg::CNT_RESET;
			any_fall_reg <= 1'b0;
		end
		else if (clk_fall)
		begin
			fall_cnt_reg <= fall_cnt_reg + 3'h1; // [RQ21]
			any_fall_reg <= 1'b1;
		end
	end

	// commands and frame error settle at select rise only
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			cmd_reg       <= qss_pkg::CMD_RESET;
			frame_error_n <= 1'b1;
		end
		else if (sel_rise)
		begin
			frame_error_n <= frame_ok;        // [RQ12] [RQ13] [RQ14] [RQ27]
			if (frame_ok && any_fall_reg)
				cmd_reg <= rx_frame.cmd;      // [RQ22] [RQ26]
		end
	end

	// held overload flags; a new overload wins over the clear
	assign held_set = cmd_reg & pins_reg.overtemp;                              // [RQ17]
	assign held_clr = {4{sel_rise & frame_ok}} & ~pins_reg.overtemp;           // [RQ18]

	always_ff @(posedge core_clk)
	begin
		if (rst)
			held_reg <= qss_pkg::CMD_RESET;
		else
			held_reg <= held_set | (held_reg & ~held_clr); // [RQ17] [RQ18]
	end

	// retry tick divider, restarted when a hold begins
	always_ff @(posedge core_clk)
	begin
		if (rst || retry_state_reg == qss_pkg::RT_IDLE || tick_cnt_reg == TICK_LAST)
			tick_cnt_reg <= '0;
		else
			tick_cnt_reg <= tick_cnt_reg + TW'(1);
	end

	// reverse current auto-retry sequencer
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			retry_state_reg <= qss_pkg::RT_IDLE;
			retry_cnt_reg   <= '0;
		end
		else
		begin
			case (retry_state_reg)
				qss_pkg::RT_IDLE:
				begin
					retry_cnt_reg <= '0;
					if (pins_reg.reverse_detect)
						retry_state_reg <= qss_pkg::RT_HOLD; // [RQ1] [RQ3]
				end
				qss_pkg::RT_HOLD:
				begin
					if (tick_cnt_reg == TICK_LAST)
					begin
						retry_cnt_reg <= retry_cnt_reg + RW'(1);
						if (retry_cnt_reg == RETRY_LAST)
							retry_state_reg <= qss_pkg::RT_IDLE; // [RQ2]
					end
				end
				default:
					retry_state_reg <= qss_pkg::RT_IDLE;
			endcase
		end
	end

	// switch drive: command gated by overtemperature, retry hold and global off
	assign switch_next = cmd_reg                                  // [RQ10]
		& ~pins_reg.overtemp                                      // [RQ4]
		& {4{pins_reg.global_off_n}}                              // [RQ24]
		& {4{retry_state_reg == qss_pkg::RT_IDLE}};               // [RQ1] [RQ2]

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			switch_on       <= qss_pkg::CMD_RESET;
			reverse_fault_n <= 1'b1;
		end
		else
		begin
			switch_on       <= switch_next;
			reverse_fault_n <= (retry_state_reg == qss_pkg::RT_IDLE); // [RQ1] [RQ2]
		end
	end

	// fault output low means every switch is off
	property p_rev_off;
		@(posedge core_clk) disable iff (rst)
		(retry_state_reg == qss_pkg::RT_HOLD) |=> (switch_on == 4'h0) && !reverse_fault_n;
	endproperty
	a_rev_off: assert property (p_rev_off) else $error("switch on during retry hold"); // [RQ1]

	// leaving the hold releases the fault and restores the commands
	property p_rev_release;
		@(posedge core_clk) disable iff (rst)
		(retry_state_reg == qss_pkg::RT_HOLD) ##1 (retry_state_reg == qss_pkg::RT_IDLE)
		|=> reverse_fault_n && (switch_on == $past(switch_next));
	endproperty
	a_rev_release: assert property (p_rev_release) else $error("retry release wrong"); // [RQ2]

	// a reverse current seen while idle starts a new hold
	property p_rev_again;
		@(posedge core_clk) disable iff (rst)
		(retry_state_reg == qss_pkg::RT_IDLE) && pins_reg.reverse_detect
		|=> (retry_state_reg == qss_pkg::RT_HOLD) ##1 !reverse_fault_n;
	endproperty
	a_rev_again: assert property (p_rev_again) else $error("retry not restarted"); // [RQ3]

	// overtemperature or global off forces the channel off
	property p_channel_off;
		@(posedge core_clk) disable iff (rst)
		1'b1 |=> ((switch_on & $past(pins_reg.overtemp)) == 4'h0)
			&& ($past(pins_reg.global_off_n) || switch_on == 4'h0);
	endproperty
	a_channel_off: assert property (p_channel_off) else $error("switch on while forced off"); // [RQ4]

	// output enable follows select
	property p_sdo_oe;
		@(posedge core_clk) disable iff (rst)
		pins_reg.cs_n |=> !sdo_oe;
	endproperty
	a_sdo_oe: assert property (p_sdo_oe) else $error("serial output driven while idle"); // [RQ6]

	// bad parity keeps commands and lowers the error output
	property p_parity;
		@(posedge core_clk) disable iff (rst)
		sel_rise && !parity_ok |=> !frame_error_n && $stable(cmd_reg);
	endproperty
	a_parity: assert property (p_parity) else $error("parity error not handled"); // [RQ12]

	// clock count not a multiple of eight raises the error and keeps commands
	property p_count;
		@(posedge core_clk) disable iff (rst)
		sel_rise && (fall_cnt_reg != qss_pkg::CNT_RESET) |=> !frame_error_n && $stable(cmd_reg);
	endproperty
	a_count: assert property (p_count) else $error("count error not handled"); // [RQ13]

	// error output moves only at select rise
	property p_err_stable;
		@(posedge core_clk) disable iff (rst)
		!sel_rise |=> $stable(frame_error_n);
	endproperty
	a_err_stable: assert property (p_err_stable) else $error("frame error moved mid frame"); // [RQ14]

	// diagnostics for channels commanded off read zero
	property p_diag_zero;
		@(posedge core_clk) disable iff (rst)
		sel_fall |=> ((shift_reg[7:4] | shift_reg[3:0]) & ~cmd_reg) == 4'h0;
	endproperty
	a_diag_zero: assert property (p_diag_zero) else $error("off channel reports a flag"); // [RQ16]

	// an active overload leaves the held flag set
	property p_held_set;
		@(posedge core_clk) disable iff (rst)
		(held_set != 4'h0) |=> ((held_reg & $past(held_set)) == $past(held_set));
	endproperty
	a_held_set: assert property (p_held_set) else $error("held flag lost"); // [RQ17]

	// edges outside a transaction leave the counter alone
	property p_idle_clk;
		@(posedge core_clk) disable iff (rst)
		pins_reg.cs_n && pins_prev_reg.cs_n |=> $stable(fall_cnt_reg) && $stable(shift_reg);
	endproperty
	a_idle_clk: assert property (p_idle_clk) else $error("idle clock counted"); // [RQ19]

	// a clean frame applies its commands and clears the error
	property p_apply;
		@(posedge core_clk) disable iff (rst)
		sel_rise && frame_ok && any_fall_reg |=> frame_error_n && (cmd_reg == $past(rx_frame.cmd));
	endproperty
	a_apply: assert property (p_apply) else $error("clean frame not applied"); // [RQ22]
endmodule
`default_nettype wire

// ### tb/qss_host_model.sv
// qss_host_model: behavioural mode-0 serial host for the switch control block.
// assumes the bench core clock paces it; one link clock period is eight core cycles.
`timescale 1ns/100ps
`default_nettype none
module qss_host_model (
	input  wire logic core_clk, // core clock used as time base
	output logic      spi_clk,  // serial clock, idles low
	output logic      cs_n,     // chip select, active low
	output logic      sdi,      // serial data to the device
	input  wire logic sdo,      // serial data from the device
	input  wire logic sdo_oe    // device drive enable
);
	// idle levels at time zero
	initial
	begin
		spi_clk = 1'b0;
		cs_n    = 1'b1;
		sdi     = 1'b1;
	end
	// wait a number of core cycles
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// one transaction of n bits msb first; sel low keeps select high
	task automatic xfer(input logic [15:0] data, input int n, input bit sel,
		output logic [15:0] rx);
		rx = 16'h0000;
		@(posedge core_clk);
		cs_n <= ~sel;
		tick(8); // clock held low at select edge
		for (int i = 0; i < n; i++)
		begin
			sdi <= data[n-1-i]; // msb first, changed after the fall
			tick(4);
			spi_clk <= 1'b1; // 80 ns period, 12.5 MHz, above the 10 MHz maximum rate
			tick(3);
			@(negedge core_clk);
			rx = {rx[14:0], sdo_oe ? sdo : 1'bx}; // undriven output reads unknown
			@(posedge core_clk);
			spi_clk <= 1'b0;
		end
		tick(8);
		cs_n <= 1'b1;
		sdi  <= ~sdi; // released line shows the inverse
		tick(12);
	endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// tb_top: self-checking bench for the quad switch serial control block.
// assumes qss_host_model drives the link; retry counts are shortened.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	localparam int TICKS = 4;
	localparam int RETRIES = 5;
	localparam int HOLD = TICKS * RETRIES;
	localparam int LIMIT = 20000;
	logic        core_clk;
	logic        rst;
	logic        reverse_detect;
	logic        global_off_n;
	logic [3:0]  overtemp;
	logic [15:0] rx;
	int          mismatches;
	int          num_checks;
	int          cycles;
	wire         spi_clk;
	wire         cs_n;
	wire         sdi;
	wire [3:0]   switch_on;
	wire         reverse_fault_n;
	wire         frame_error_n;
	wire         sdo;
	wire         sdo_oe;
	// device under test
	qss_serial_control #(.TICK_CYCLES(TICKS), .RETRY_TICKS(RETRIES)) qss_serial_control_i (
		.core_clk(core_clk), .rst(rst), .spi_clk(spi_clk), .cs_n(cs_n), .sdi(sdi),
		.reverse_detect(reverse_detect), .global_off_n(global_off_n), .overtemp(overtemp),
		.switch_on(switch_on), .reverse_fault_n(reverse_fault_n),
		.frame_error_n(frame_error_n), .sdo(sdo), .sdo_oe(sdo_oe));
	// far side host
	qss_host_model qss_host_model_i (.core_clk(core_clk), .spi_clk(spi_clk), .cs_n(cs_n),
		.sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));
	// clock and time-zero inputs
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial
	begin
		rst = 1'b1;
		reverse_detect = 1'b0;
		global_off_n = 1'b1;
		overtemp = 4'h0;
		mismatches = 0;
		num_checks = 0;
		cycles = 0;
	end
	// hang guard
	always @(posedge core_clk)
	begin
		cycles = cycles + 1;
		if (cycles == LIMIT)
		begin
			mismatches++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// expected frame: commands then odd, even, all, inverted all parity
	function automatic logic [7:0] mk(input logic [3:0] c);
		return {c, c[0] ^ c[2], c[1] ^ c[3], ^c, ~^c};
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic send(input logic [15:0] d, input int n);
		qss_host_model_i.xfer(d, n, 1'b1, rx);
	endtask
	// every command value, diagnostics clear
	task automatic t_cmds();
		for (int c = 0; c < 16; c++)
		begin
			send(16'(mk(4'(c))), 8);
			check(8'(switch_on), 8'(c));
			check(8'(frame_error_n), 8'h01);
			check(rx[7:0], 8'h00);
		end
	endtask
	// each parity bit wrong, then a clean frame
	task automatic t_parity();
		send(16'(mk(4'h5)), 8);
		for (int k = 0; k < 4; k++)
		begin
			send(16'(mk(4'hA) ^ (8'h01 << k)), 8);
			check(8'(switch_on), 8'h05);
			check(8'(frame_error_n), 8'h00);
		end
		send(16'(mk(4'h5)), 8);
		check(8'(frame_error_n), 8'h01);
	endtask
	// seven and nine clock pulses
	task automatic t_count();
		send(16'(mk(4'h3) >> 1), 7);
		check(8'(switch_on), 8'h05);
		check(8'(frame_error_n), 8'h00);
		send(16'(mk(4'h3)), 9);
		check(8'(switch_on), 8'h05);
		check(8'(frame_error_n), 8'h00);
	endtask
	// two chained bytes, then pulses with select high
	task automatic t_chain();
		send({mk(4'h9), mk(4'h6)}, 16);
		check(8'(switch_on), 8'h06);
		check(rx[7:0], mk(4'h9));
		check(8'(frame_error_n), 8'h01);
		qss_host_model_i.xfer(16'hFFFF, 5, 1'b0, rx);
		check({switch_on, 3'h0, frame_error_n}, 8'h61);
		send(16'(mk(4'hC)), 8);
		check(8'(frame_error_n), 8'h01);
		check(8'(switch_on), 8'h0C);
	endtask
	// thermal cut, restart and held flag handling
	task automatic t_thermal();
		send(16'(mk(4'hF)), 8);
		overtemp <= 4'h2;
		cyc(10);
		check(8'(switch_on), 8'h0D);
		send(16'(mk(4'hF)), 8);
		check(rx[7:0], 8'h22);
		overtemp <= 4'h0;
		cyc(10);
		check(8'(switch_on), 8'h0F);
		send(16'(mk(4'hF)), 8);
		check(rx[7:0], 8'h02);
		send(16'(mk(4'hF)), 8);
		check(rx[7:0], 8'h00);
		overtemp <= 4'h1;
		cyc(10);
		overtemp <= 4'h0;
		cyc(10);
		send(16'(mk(4'hF) >> 1), 7);
		send(16'(mk(4'hE)), 8);
		check(rx[7:0], 8'h01);
		overtemp <= 4'h1;
		cyc(10);
		send(16'(mk(4'hE)), 8);
		check(rx[7:0], 8'h00);
		overtemp <= 4'h0;
	endtask
	// global off, reverse retry and repeated retry
	task automatic t_off_rev();
		global_off_n <= 1'b0;
		cyc(8);
		check(8'(switch_on), 8'h00);
		global_off_n <= 1'b1;
		cyc(8);
		check(8'(switch_on), 8'h0E);
		reverse_detect <= 1'b1;
		cyc(3);
		reverse_detect <= 1'b0;
		cyc(8);
		check({switch_on, 3'h0, reverse_fault_n}, 8'h00);
		cyc(HOLD + 4);
		check({switch_on, 3'h0, reverse_fault_n}, 8'hE1);
		reverse_detect <= 1'b1;
		cyc(HOLD + 16);
		check({switch_on, 3'h0, reverse_fault_n}, 8'h00);
		reverse_detect <= 1'b0;
		cyc(2 * HOLD + 8);
		check({switch_on, 3'h0, reverse_fault_n}, 8'hE1);
	endtask
	// main sequence
	initial
	begin
		cyc(12);
		rst <= 1'b0;
		cyc(4);
		check({switch_on, frame_error_n, reverse_fault_n, sdo_oe, 1'b0}, 8'h0C);
		t_cmds();
		t_parity();
		t_count();
		t_chain();
		t_thermal();
		t_off_rev();
		print_verdict();
	end
endmodule
`default_nettype wire
